//--- design/tcu_pkg.sv
// Package: register map, field layout, reset values and bus carriers
package tcu_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SET_EN = 8'h00;
	localparam logic [7:0] OFS_RST_EN = 8'h04;
	localparam logic [7:0] OFS_SET_CMP = 8'h08;
	localparam logic [7:0] OFS_RST_CMP = 8'h0c;
	localparam logic [7:0] OFS_TGL_CMP = 8'h10;
	localparam logic [7:0] OFS_COUNT = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
	localparam logic [7:0] OFS_IRQ_EN = 8'h20;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int SR_N = 6;
	localparam int TGL_N = 2;
	localparam int TGL0_BIT = 6;
	localparam int TGL1_BIT = 7;
	localparam int IRQ_N = 3;
	localparam int IRQ_SET_BIT = 0;
	localparam int IRQ_RST_BIT = 1;
	localparam int IRQ_TGL_BIT = 2;

	// ----------------------------------------------------------------
	// Reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] COUNT_STEP = 16'h0001;
	localparam logic [15:0] CMP_RST = 16'h0000;
	localparam logic [5:0] SET_EN_RST = 6'h00;
	localparam logic [7:0] RST_EN_RST = 8'h00;
	localparam logic [5:0] SR_RST = 6'h00;
	localparam logic [1:0] TGL_RST = 2'h0;
	localparam logic [2:0] IRQ_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Bus carriers and write channel states
	// ----------------------------------------------------------------
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} tcu_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tcu_axi_rsp_t;

	typedef enum logic [1:0] {
		WR_IDLE = 2'h0,
		WR_ADDR = 2'h1,
		WR_RESP = 2'h3,
		WR_DATA = 2'h2
	} tcu_wr_state_t;

endpackage

//--- design/tcu_cmp_match.sv
// Module: single compare channel, one pulse per first equality
`timescale 1ns/1ps
module tcu_cmp_match (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [15:0] count_i,
	input wire logic [15:0] cmp_i,
	output logic match_o
);

	logic eq;
	logic eq_last_reg;

	assign eq = (count_i == cmp_i);

	// Edge of equality only, so a held count cannot repeat the event
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			eq_last_reg <= 1'b0;
			match_o <= 1'b0;
		end else begin
			eq_last_reg <= eq;
			match_o <= eq && !eq_last_reg; // RULE13
		end
	end

endmodule

//--- design/tcu_compare_unit.sv
// Module: timer compare output unit with its AXI4-Lite register slave
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// RULE1 - One 16-bit compare register drives both toggle outputs on match.
// RULE2 - Mask bit 6 clear blocks toggle pulse; first flip flop holds.
// RULE3 - Mask bit 7 set: each toggle match inverts second flip flop.
// RULE4 - Set-enable mask reads toggle states in bits 6 and 7.
// RULE5 - Toggle state fixable by software via one enabled early match.
// RULE6 - Set-enable bits are each writable between set matches.
// RULE7 - Set match flag stays until software clears it.
// RULE8 - Set/reset outputs act independently and may overlap.
// RULE9 - Set match sets each output whose set-enable bit 0..5 is one.
// RULE10 - Reset match clears each output whose reset-enable bit is one.
// RULE11 - Toggle flip flops have no software write path.
// RULE12 - Set and reset matches each raise their own interrupt flag.
// RULE13 - A match is detected once, in the first equal cycle.
// RULE14 - Toggle match raises its own sticky interrupt flag.
module tcu_compare_unit (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire tcu_pkg::tcu_axi_req_t axi_req_i,
	output tcu_pkg::tcu_axi_rsp_t axi_rsp_o,
	output logic [5:0] sr_out_o,
	output logic [1:0] toggle_out_o,
	output logic irq_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [15:0] count_reg;
	logic [15:0] set_compare_register;
	logic [15:0] reset_compare_register;
	logic [15:0] toggle_compare_register;
	logic [5:0] set_enable_mask;
	logic [7:0] reset_toggle_enable_mask;
	logic [5:0] sr_reg;
	logic [5:0] sr_next;
	logic [1:0] tgl_reg;
	logic [1:0] tgl_next;
	logic [2:0] timer_interrupt_flag_register;
	logic [2:0] flag_next;
	logic [2:0] irq_en_reg;
	logic irq_reg;
	logic set_compare_match_flag;
	logic rst_match;
	logic tgl_match;
	logic [2:0] events;
	logic [2:0] clr_bits;

	tcu_pkg::tcu_wr_state_t wr_state_reg;
	tcu_pkg::tcu_wr_state_t wr_state_next;
	tcu_pkg::tcu_axi_rsp_t rsp_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic aw_take;
	logic w_take;
	logic wr_do;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_hit;
	logic ar_take;
	logic r_done;
	logic [31:0] rd_data;
	logic rd_hit;

	// ----------------------------------------------------------------
	// Byte lane merge for the 16-bit registers
	// ----------------------------------------------------------------
	function automatic logic [15:0] merge16(
		input logic [15:0] old_val,
		input logic [31:0] data,
		input logic [3:0] strb
	);
		logic [15:0] res;
		res = old_val;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// Timer count
	// ----------------------------------------------------------------
	// Free running; wraps at 16 bits like the timer it stands for
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			count_reg <= tcu_pkg::COUNT_RST;
		end else begin
			count_reg <= count_reg + tcu_pkg::COUNT_STEP;
		end
	end

	// ----------------------------------------------------------------
	// Compare channels
	// ----------------------------------------------------------------
	tcu_cmp_match u_set_cmp (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.count_i(count_reg),
		.cmp_i(set_compare_register),
		.match_o(set_compare_match_flag)
	);

	tcu_cmp_match u_rst_cmp (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.count_i(count_reg),
		.cmp_i(reset_compare_register),
		.match_o(rst_match)
	);

	// Single source for both toggle outputs
	tcu_cmp_match u_tgl_cmp (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.count_i(count_reg),
		.cmp_i(toggle_compare_register), // RULE1
		.match_o(tgl_match)
	);

	// ----------------------------------------------------------------
	// Set/reset outputs
	// ----------------------------------------------------------------
	// Per bit gating, so outputs never interact; reset wins a tie
	always_comb begin
		sr_next = sr_reg;
		if (set_compare_match_flag) begin
			sr_next = sr_next | set_enable_mask; // RULE9 RULE8
		end
		if (rst_match) begin
			sr_next = sr_next & ~reset_toggle_enable_mask[5:0]; // RULE10
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			sr_reg <= tcu_pkg::SR_RST;
		end else begin
			sr_reg <= sr_next;
		end
	end

	// ----------------------------------------------------------------
	// Toggle flip flops
	// ----------------------------------------------------------------
	// Driven by matches only; no bus write reaches them
	always_comb begin
		tgl_next = tgl_reg;
		if (tgl_match && reset_toggle_enable_mask[tcu_pkg::TGL0_BIT]) begin
			tgl_next[0] = ~tgl_reg[0]; // RULE2
		end
		if (tgl_match && reset_toggle_enable_mask[tcu_pkg::TGL1_BIT]) begin
			tgl_next[1] = ~tgl_reg[1]; // RULE3
		end
	end

	// Reset to a known level anyway; software may still retoggle
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			tgl_reg <= tcu_pkg::TGL_RST;
		end else begin
			tgl_reg <= tgl_next; // RULE11 RULE5
		end
	end

	// ----------------------------------------------------------------
	// Interrupt flags
	// ----------------------------------------------------------------
	assign events = {tgl_match, rst_match, set_compare_match_flag};

	always_comb begin
		clr_bits = 3'h0;
		if (wr_do && wr_addr == tcu_pkg::OFS_IRQ_CLR && wr_strb[0]) begin
			clr_bits = wr_data[2:0];
		end
		// A new event outranks a clear in the same cycle
		flag_next = (timer_interrupt_flag_register & ~clr_bits) | events;
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			timer_interrupt_flag_register <= tcu_pkg::IRQ_RST;
		end else begin
			timer_interrupt_flag_register <= flag_next; // RULE7 RULE12 RULE14
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(timer_interrupt_flag_register & irq_en_reg); // RULE12
		end
	end

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	assign aw_take = axi_req_i.awvalid && rsp_reg.awready;
	assign w_take = axi_req_i.wvalid && rsp_reg.wready;
	assign wr_addr = aw_take ? axi_req_i.awaddr : aw_addr_reg;
	assign wr_data = w_take ? axi_req_i.wdata : w_data_reg;
	assign wr_strb = w_take ? axi_req_i.wstrb : w_strb_reg;
	assign wr_do = (wr_state_reg != tcu_pkg::WR_RESP) &&
		(wr_state_next == tcu_pkg::WR_RESP);

	always_comb begin
		wr_state_next = wr_state_reg;
		case (wr_state_reg)
			tcu_pkg::WR_IDLE: begin
				if (aw_take && w_take) begin
					wr_state_next = tcu_pkg::WR_RESP;
				end else if (aw_take) begin
					wr_state_next = tcu_pkg::WR_ADDR;
				end else if (w_take) begin
					wr_state_next = tcu_pkg::WR_DATA;
				end
			end
			tcu_pkg::WR_ADDR: begin
				if (w_take) begin
					wr_state_next = tcu_pkg::WR_RESP;
				end
			end
			tcu_pkg::WR_DATA: begin
				if (aw_take) begin
					wr_state_next = tcu_pkg::WR_RESP;
				end
			end
			tcu_pkg::WR_RESP: begin
				if (axi_req_i.bready) begin
					wr_state_next = tcu_pkg::WR_IDLE;
				end
			end
			default: begin
				wr_state_next = tcu_pkg::WR_IDLE;
			end
		endcase
	end

	always_comb begin
		case (wr_addr)
			tcu_pkg::OFS_SET_EN,
			tcu_pkg::OFS_RST_EN,
			tcu_pkg::OFS_SET_CMP,
			tcu_pkg::OFS_RST_CMP,
			tcu_pkg::OFS_TGL_CMP,
			tcu_pkg::OFS_IRQ_CLR,
			tcu_pkg::OFS_IRQ_EN: begin
				wr_hit = 1'b1;
			end
			default: begin
				wr_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			wr_state_reg <= tcu_pkg::WR_IDLE;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else begin
			wr_state_reg <= wr_state_next;
			if (aw_take) begin
				aw_addr_reg <= axi_req_i.awaddr;
			end
			if (w_take) begin
				w_data_reg <= axi_req_i.wdata;
				w_strb_reg <= axi_req_i.wstrb;
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			set_enable_mask <= tcu_pkg::SET_EN_RST;
			reset_toggle_enable_mask <= tcu_pkg::RST_EN_RST;
			irq_en_reg <= tcu_pkg::IRQ_RST;
		end else if (wr_do && wr_strb[0]) begin
			case (wr_addr)
				tcu_pkg::OFS_SET_EN: begin
					// Bits 6 and 7 are state readback, not storage
					set_enable_mask <= wr_data[5:0]; // RULE6
				end
				tcu_pkg::OFS_RST_EN: begin
					reset_toggle_enable_mask <= wr_data[7:0];
				end
				tcu_pkg::OFS_IRQ_EN: begin
					irq_en_reg <= wr_data[2:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			set_compare_register <= tcu_pkg::CMP_RST;
			reset_compare_register <= tcu_pkg::CMP_RST;
			toggle_compare_register <= tcu_pkg::CMP_RST;
		end else if (wr_do) begin
			case (wr_addr)
				tcu_pkg::OFS_SET_CMP: begin
					set_compare_register <=
						merge16(set_compare_register, wr_data, wr_strb);
				end
				tcu_pkg::OFS_RST_CMP: begin
					reset_compare_register <=
						merge16(reset_compare_register, wr_data, wr_strb);
				end
				tcu_pkg::OFS_TGL_CMP: begin
					toggle_compare_register <=
						merge16(toggle_compare_register, wr_data, wr_strb);
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	assign ar_take = axi_req_i.arvalid && rsp_reg.arready;
	assign r_done = rsp_reg.rvalid && axi_req_i.rready;

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		case (axi_req_i.araddr)
			tcu_pkg::OFS_SET_EN: begin
				rd_data[5:0] = set_enable_mask;
				rd_data[tcu_pkg::TGL0_BIT] = tgl_reg[0]; // RULE4
				rd_data[tcu_pkg::TGL1_BIT] = tgl_reg[1]; // RULE4
			end
			tcu_pkg::OFS_RST_EN: begin
				rd_data[7:0] = reset_toggle_enable_mask;
			end
			tcu_pkg::OFS_SET_CMP: begin
				rd_data[15:0] = set_compare_register;
			end
			tcu_pkg::OFS_RST_CMP: begin
				rd_data[15:0] = reset_compare_register;
			end
			tcu_pkg::OFS_TGL_CMP: begin
				rd_data[15:0] = toggle_compare_register;
			end
			tcu_pkg::OFS_COUNT: begin
				rd_data[15:0] = count_reg;
			end
			tcu_pkg::OFS_IRQ_STAT: begin
				rd_data[2:0] = timer_interrupt_flag_register;
			end
			tcu_pkg::OFS_IRQ_CLR: begin
				rd_data = 32'h0000_0000;
			end
			tcu_pkg::OFS_IRQ_EN: begin
				rd_data[2:0] = irq_en_reg;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Bus answers, all registered
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rsp_reg.awready <= 1'b0;
			rsp_reg.wready <= 1'b0;
			rsp_reg.bvalid <= 1'b0;
			rsp_reg.bresp <= tcu_pkg::RESP_OKAY;
		end else begin
			rsp_reg.awready <= (wr_state_next == tcu_pkg::WR_IDLE) ||
				(wr_state_next == tcu_pkg::WR_DATA);
			rsp_reg.wready <= (wr_state_next == tcu_pkg::WR_IDLE) ||
				(wr_state_next == tcu_pkg::WR_ADDR);
			rsp_reg.bvalid <= (wr_state_next == tcu_pkg::WR_RESP);
			if (wr_do) begin
				rsp_reg.bresp <= wr_hit ? tcu_pkg::RESP_OKAY :
					tcu_pkg::RESP_SLVERR;
			end
		end
	end

	// One read in flight; arready drops while the answer waits
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			rsp_reg.arready <= 1'b0;
			rsp_reg.rvalid <= 1'b0;
			rsp_reg.rdata <= 32'h0000_0000;
			rsp_reg.rresp <= tcu_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rsp_reg.arready <= 1'b0;
			rsp_reg.rvalid <= 1'b1;
			rsp_reg.rdata <= rd_data;
			rsp_reg.rresp <= rd_hit ? tcu_pkg::RESP_OKAY :
				tcu_pkg::RESP_SLVERR;
		end else if (r_done || !rsp_reg.rvalid) begin
			rsp_reg.arready <= 1'b1;
			rsp_reg.rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign axi_rsp_o = rsp_reg;
	assign sr_out_o = sr_reg;
	assign toggle_out_o = tgl_reg;
	assign irq_o = irq_reg;

endmodule

//--- sim/tcu_pin_model.sv
// Model of the driver circuits hanging on the toggle output pins
`timescale 1ns/1ps
module tcu_pin_model (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [1:0] toggle_out_i,
	output logic [15:0] tgl_edges_o
);
	// ----------------------------------------------------------------
	// Edge counters
	// ----------------------------------------------------------------
	logic [1:0] last_reg;
	logic [7:0] cnt0_reg;
	logic [7:0] cnt1_reg;
	assign tgl_edges_o = {cnt1_reg, cnt0_reg};
	// Coil drivers act on level changes, so each change is one event
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			last_reg <= 2'h0;
			cnt0_reg <= 8'h00;
			cnt1_reg <= 8'h00;
		end else begin
			last_reg <= toggle_out_i;
			if (toggle_out_i[0] != last_reg[0]) cnt0_reg <= cnt0_reg + 8'h01;
			if (toggle_out_i[1] != last_reg[1]) cnt1_reg <= cnt1_reg + 8'h01;
		end
	end
endmodule

//--- sim/tcu_compare_unit_asserts.sv
// Checker: port-level properties of the compare output unit
`timescale 1ns/1ps
module tcu_compare_unit_asserts (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire tcu_pkg::tcu_axi_req_t axi_req_i,
	input wire tcu_pkg::tcu_axi_rsp_t axi_rsp_o,
	input wire logic [5:0] sr_out_o,
	input wire logic [1:0] toggle_out_o,
	input wire logic irq_o
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);
	logic ar_take;
	logic aw_take;
	assign ar_take = axi_req_i.arvalid && axi_rsp_o.arready;
	assign aw_take = axi_req_i.awvalid && axi_rsp_o.awready &&
		axi_req_i.wvalid && axi_rsp_o.wready;
	property p_quiet;
		$fell(reset_i) |-> sr_out_o == 6'h00 && toggle_out_o == 2'h0 && !irq_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("outputs not idle");
	property p_bvalid_after;
		aw_take |=> axi_rsp_o.bvalid;
	endproperty
	a_bvalid_after: assert property (p_bvalid_after) else $error("no bvalid");
	property p_aw_blocked;
		axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready;
	endproperty
	a_aw_blocked: assert property (p_aw_blocked) else $error("write ready");
	property p_rvalid_after;
		ar_take |=> axi_rsp_o.rvalid && !axi_rsp_o.arready;
	endproperty
	a_rvalid_after: assert property (p_rvalid_after) else $error("no rvalid");
	property p_slverr;
		ar_take && axi_req_i.araddr > tcu_pkg::OFS_IRQ_EN |=>
			axi_rsp_o.rresp == tcu_pkg::RESP_SLVERR;
	endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped not refused");
	property p_clr_zero;
		ar_take && axi_req_i.araddr == tcu_pkg::OFS_IRQ_CLR |=>
			axi_rsp_o.rdata == 32'h0;
	endproperty
	a_clr_zero: assert property (p_clr_zero) else $error("clear reads nonzero");
	property p_tgl_state;
		ar_take && axi_req_i.araddr == tcu_pkg::OFS_SET_EN |=>
			axi_rsp_o.rdata[7:6] == $past(toggle_out_o) &&
			axi_rsp_o.rdata[31:8] == 24'h0;
	endproperty
	a_tgl_state: assert property (p_tgl_state) else $error("toggle state");
	property p_tgl_once;
		$changed(toggle_out_o) |=> $stable(toggle_out_o) [*2];
	endproperty
	a_tgl_once: assert property (p_tgl_once) else $error("double toggle");
	// A flag can only fall through a completed register write
	property p_irq_sticky;
		irq_o && !axi_rsp_o.bvalid |=> irq_o;
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped");
endmodule
bind tcu_compare_unit tcu_compare_unit_asserts u_tcu_compare_unit_asserts (
	.core_clk_i(core_clk_i),
	.reset_i(reset_i),
	.axi_req_i(axi_req_i),
	.axi_rsp_o(axi_rsp_o),
	.sr_out_o(sr_out_o),
	.toggle_out_o(toggle_out_o),
	.irq_o(irq_o)
);

//--- sim/tcu_compare_unit_tb_top.sv
// Testbench: register-level tests of the compare output unit
`timescale 1ns/1ps
module tcu_compare_unit_tb_top;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	tcu_pkg::tcu_axi_req_t req = '0;
	tcu_pkg::tcu_axi_rsp_t rsp;
	logic [5:0] sr_out;
	logic [1:0] tgl_out;
	logic irq;
	logic [15:0] tgl_edges;
	logic [31:0] rd;
	logic [1:0] resp;
	logic [3:0] strb = 4'hf;
	int failures = 0;
	int tests_run = 0;
	logic [7:0] rv_ofs [6] = '{tcu_pkg::OFS_SET_EN, tcu_pkg::OFS_RST_EN,
		tcu_pkg::OFS_SET_CMP, tcu_pkg::OFS_RST_CMP, tcu_pkg::OFS_TGL_CMP,
		tcu_pkg::OFS_IRQ_EN};
	always #12.5 core_clk_i = ~core_clk_i;
	tcu_compare_unit u_tcu_compare_unit (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.axi_req_i(req),
		.axi_rsp_o(rsp),
		.sr_out_o(sr_out),
		.toggle_out_o(tgl_out),
		.irq_o(irq)
	);
	tcu_pin_model u_tcu_pin_model (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.toggle_out_i(tgl_out),
		.tgl_edges_o(tgl_edges)
	);
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Bready is offered up front; the slave may answer at once
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit done;
		done = 1'b0;
		@(posedge core_clk_i);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= strb;
		req.bready <= 1'b1;
		while (!done) begin
			@(posedge core_clk_i);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (req.bready && rsp.bvalid) begin
				resp = rsp.bresp;
				req.bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic rdt(input logic [7:0] a);
		bit done;
		done = 1'b0;
		@(posedge core_clk_i);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		while (!done) begin
			@(posedge core_clk_i);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (req.rready && rsp.rvalid) begin
				rd = rsp.rdata;
				resp = rsp.rresp;
				req.rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
		input string nm);
		rdt(a);
		chk(nm, exp, rd);
		chk("rresp", {30'h0, tcu_pkg::RESP_OKAY}, {30'h0, resp});
	endtask
	// Compare lands k counts after the counter was read
	task automatic arm(input logic [7:0] a, input logic [15:0] k);
		rdt(tcu_pkg::OFS_COUNT);
		wr(a, {16'h0, rd[15:0] + k});
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk_i);
		reset_i <= 1'b0;
		@(posedge core_clk_i);
		for (int i = 0; i < 6; i++) begin
			rchk(rv_ofs[i], 32'h0, "reset value");
		end
		rchk(tcu_pkg::OFS_IRQ_CLR, 32'h0, "clear readback");
		wr(8'h40, 32'h1);
		chk("bresp", {30'h0, tcu_pkg::RESP_SLVERR}, {30'h0, resp});
		rdt(8'h40);
		chk("rresp", {30'h0, tcu_pkg::RESP_SLVERR}, {30'h0, resp});
		$display("Test registers done");
		// Start-up matches against zero compares may have left flags
		wr(tcu_pkg::OFS_IRQ_CLR, 32'h7);
		wr(tcu_pkg::OFS_SET_EN, 32'h05);
		wr(tcu_pkg::OFS_RST_EN, 32'h01);
		arm(tcu_pkg::OFS_SET_CMP, 16'd30);
		arm(tcu_pkg::OFS_RST_CMP, 16'd90);
		repeat (40) @(posedge core_clk_i);
		chk("sr_out set", 32'h05, {26'h0, sr_out});
		repeat (60) @(posedge core_clk_i);
		chk("sr_out reset", 32'h04, {26'h0, sr_out});
		rchk(tcu_pkg::OFS_IRQ_STAT, 32'h3, "flags");
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(tcu_pkg::OFS_IRQ_EN, 32'h1);
		repeat (2) @(posedge core_clk_i);
		chk("irq raised", 32'h1, {31'h0, irq});
		wr(tcu_pkg::OFS_IRQ_CLR, 32'h2);
		rchk(tcu_pkg::OFS_IRQ_STAT, 32'h1, "sticky flag");
		chk("irq held", 32'h1, {31'h0, irq});
		wr(tcu_pkg::OFS_IRQ_CLR, 32'h1);
		repeat (2) @(posedge core_clk_i);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("Test set reset done");
		wr(tcu_pkg::OFS_SET_EN, 32'h02);
		arm(tcu_pkg::OFS_SET_CMP, 16'd30);
		repeat (40) @(posedge core_clk_i);
		chk("sr_out rearm", 32'h06, {26'h0, sr_out});
		$display("Test rearm done");
		wr(tcu_pkg::OFS_RST_EN, 32'h80);
		arm(tcu_pkg::OFS_TGL_CMP, 16'd30);
		repeat (40) @(posedge core_clk_i);
		chk("toggle", 32'h2, {30'h0, tgl_out});
		rchk(tcu_pkg::OFS_SET_EN, 32'h82, "toggle state");
		rchk(tcu_pkg::OFS_IRQ_STAT, 32'h5, "toggle flag");
		wr(tcu_pkg::OFS_RST_EN, 32'h40);
		arm(tcu_pkg::OFS_TGL_CMP, 16'd30);
		repeat (40) @(posedge core_clk_i);
		chk("toggle fixed", 32'h3, {30'h0, tgl_out});
		chk("toggle edges", 32'h0101, {16'h0, tgl_edges});
		wr(tcu_pkg::OFS_SET_EN, 32'h00);
		rchk(tcu_pkg::OFS_SET_EN, 32'hc0, "no write path");
		$display("Test toggle done");
		// Upper lane only: compares merge it, masks need lane zero
		wr(tcu_pkg::OFS_SET_CMP, 32'h1234);
		strb = 4'h2;
		wr(tcu_pkg::OFS_SET_CMP, 32'h0000_5678);
		wr(tcu_pkg::OFS_SET_EN, 32'h3f);
		strb = 4'hf;
		rchk(tcu_pkg::OFS_SET_CMP, 32'h5634, "byte lanes");
		rchk(tcu_pkg::OFS_SET_EN, 32'hc0, "strobe gate");
		wr(tcu_pkg::OFS_COUNT, 32'h0);
		chk("count write", {30'h0, tcu_pkg::RESP_SLVERR}, {30'h0, resp});
		$display("Test strobes done");
		// Both compares on one count: reset must win on output 3
		wr(tcu_pkg::OFS_IRQ_CLR, 32'h7);
		wr(tcu_pkg::OFS_SET_EN, 32'h08);
		wr(tcu_pkg::OFS_RST_EN, 32'h08);
		rdt(tcu_pkg::OFS_COUNT);
		wr(tcu_pkg::OFS_SET_CMP, {16'h0, rd[15:0] + 16'd40});
		wr(tcu_pkg::OFS_RST_CMP, {16'h0, rd[15:0] + 16'd40});
		repeat (50) @(posedge core_clk_i);
		chk("reset wins", 32'h06, {26'h0, sr_out});
		rchk(tcu_pkg::OFS_IRQ_STAT, 32'h3, "tie flags");
		$display("Test tie done");
		finish_test();
	end
	// Whole run is under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk_i);
		failures++;
		$display("Error watchdog expected done seen timeout");
		finish_test();
	end
endmodule
